// [ftbi_irq.sv]
// Interrupt status, mask and sense logic for regulator faults, die temperature and power button.
`timescale 1ns/100ps

//Contract
// RQ1: A set status bit with a clear mask bit pulls the interrupt request pin low.
// RQ2: A set mask bit keeps its status bit off the pin while the status still records the event.
// RQ3: Regulator fault mask bits 0 to 2 are read-write and reset to 1.
// RQ4: Regulator fault sense bits 0 to 2 read the live fault level, read-only, reset 0.
// RQ5: Thermal status bit 0 sets on any 110 C crossing and bit 2 on any 125 C crossing.
// RQ6: Writing 1 to a status bit clears it.
// RQ7: Status bits stay set until cleared and reset to 0.
// RQ8: Thermal mask bits 0 and 2 are read-write, reset to 1, and bit 1 is unused.
// RQ9: Thermal sense bit 0 reads 1 above 110 C and 0 below, read-only, reset 0.
// RQ10: Thermal sense bit 2 reads 1 above 125 C and 0 below, read-only, reset 0.
// RQ11: Button status bit 0 sets when the button stays low past the falling debounce time.
// RQ12: Button status bit 0 also sets on a release held past the rising debounce after a valid press.
// RQ13: The push flag rises on every change of the debounced push sense in either direction.
// RQ14: Button status bits 1, 2 and 3 set after the press lasts over 1 s, 2 s and 3 s.
// RQ15: The pin is low while any unmasked status bit is set in any register, else released.
// RQ16: Unused bit positions read 0 and ignore writes.
module ftbi_irq
    import ftbi_pkg::*;
#(
    parameter int unsigned FALL_DEBOUNCE_CYCLES = FTBI_FALL_DEBOUNCE_CYC,
    parameter int unsigned RISE_DEBOUNCE_CYCLES = FTBI_RISE_DEBOUNCE_CYC,
    parameter int unsigned HOLD1_CYCLES = FTBI_HOLD1_CYC,
    parameter int unsigned HOLD2_CYCLES = FTBI_HOLD2_CYC,
    parameter int unsigned HOLD3_CYCLES = FTBI_HOLD3_CYC
) (
    // Clock, reset and clock enable.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register access from the control interface.
    input wire ftbi_req_t req,
    output logic [7:0] rd_data,
    // Live conditions and button pin.
    input wire ftbi_cond_t cond,
    input wire logic power_button,
    // Interrupt request toward the host, active low.
    output logic irq_request_low
);

    // Sense registers and their next values.
    logic [7:0] reg_fault_sense;
    logic [7:0] temp_sense;
    logic [7:0] next_reg_fault_sense;
    logic [7:0] next_temp_sense;

    // Status registers and their next values.
    logic [7:0] reg_fault_stat;
    logic [7:0] temp_stat;
    logic [7:0] btn_stat;
    logic [7:0] next_reg_fault_stat;
    logic [7:0] next_temp_stat;
    logic [7:0] next_btn_stat;

    // Mask registers and their next values.
    logic [7:0] reg_fault_mask;
    logic [7:0] temp_mask;
    logic [7:0] btn_mask;
    logic [7:0] next_reg_fault_mask;
    logic [7:0] next_temp_mask;
    logic [7:0] next_btn_mask;

    // Read data and pin next values.
    logic [7:0] next_rd_data;
    logic next_irq_request_low;

    // Button state.
    ftbi_btn_state_t btn_state;
    ftbi_btn_state_t next_btn_state;
    logic [31:0] debounce_cnt;
    logic [31:0] next_debounce_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    logic [7:0] btn_set;
    logic [7:0] temp_set;

    // Button debounce and hold timing; the pin is low while pressed.
    // The pin is taken as a clean synchronous level, so a press shorter than the falling
    // debounce leaves no trace at all; that is the point of the debounce, not a loss.
    // A press that is released and pressed again inside the rising wait keeps its hold count.
    always_comb begin
        next_btn_state = btn_state;
        next_debounce_cnt = debounce_cnt;
        next_hold_cnt = hold_cnt;
        btn_set = 8'h00;
        case (btn_state)
            FTBI_BTN_RELEASED: begin
                // Both counters rest at zero so the next press starts a fresh measurement.
                next_debounce_cnt = 32'h0;
                next_hold_cnt = 32'h0;
                if (!power_button) begin
                    next_btn_state = FTBI_BTN_FALLING;
                end
            end
            FTBI_BTN_FALLING: begin
                // A bounce back high before the time elapses restarts the wait.
                if (power_button) begin
                    next_btn_state = FTBI_BTN_RELEASED;
                    next_debounce_cnt = 32'h0;
                end else if (debounce_cnt >= FALL_DEBOUNCE_CYCLES - 32'd1) begin
                    next_btn_state = FTBI_BTN_PRESSED;
                    next_debounce_cnt = 32'h0;
                    btn_set[FTBI_BTN_PUSH_POS] = 1'b1; // [RQ11] [RQ13]
                end else begin
                    next_debounce_cnt = debounce_cnt + 32'd1;
                end
            end
            FTBI_BTN_PRESSED: begin
                next_debounce_cnt = 32'h0;
                // The hold count saturates, so a very long press cannot wrap and fire again.
                if (hold_cnt != 32'hffffffff) begin
                    next_hold_cnt = hold_cnt + 32'd1;
                end
                // Each hold flag fires once, on the cycle its count is reached.
                btn_set[FTBI_BTN_HOLD1_POS] = (hold_cnt == HOLD1_CYCLES - 32'd1); // [RQ14]
                btn_set[FTBI_BTN_HOLD2_POS] = (hold_cnt == HOLD2_CYCLES - 32'd1); // [RQ14]
                btn_set[FTBI_BTN_HOLD3_POS] = (hold_cnt == HOLD3_CYCLES - 32'd1); // [RQ14]
                if (power_button) begin
                    next_btn_state = FTBI_BTN_RISING;
                end
            end
            FTBI_BTN_RISING: begin
                // Only reachable after a press passed its debounce, so the release counts.
                if (!power_button) begin
                    next_btn_state = FTBI_BTN_PRESSED;
                    next_debounce_cnt = 32'h0;
                end else if (debounce_cnt >= RISE_DEBOUNCE_CYCLES - 32'd1) begin
                    next_btn_state = FTBI_BTN_RELEASED;
                    next_debounce_cnt = 32'h0;
                    btn_set[FTBI_BTN_PUSH_POS] = 1'b1; // [RQ12] [RQ13]
                end else begin
                    next_debounce_cnt = debounce_cnt + 32'd1;
                end
            end
            default: begin
                next_btn_state = FTBI_BTN_RELEASED;
                next_debounce_cnt = 32'h0;
                next_hold_cnt = 32'h0;
            end
        endcase
    end

    // Button timing registers; a low clock enable freezes the debounce wait as well.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            btn_state <= FTBI_BTN_RELEASED;
            debounce_cnt <= 32'h0;
            hold_cnt <= 32'h0;
        end else if (clk_en) begin
            btn_state <= next_btn_state;
            debounce_cnt <= next_debounce_cnt;
            hold_cnt <= next_hold_cnt;
        end
    end

    // Sense group: the sense registers follow the live levels one cycle later.
    // They take no writes, so a host that writes them by mistake changes nothing.
    always_comb begin
        next_reg_fault_sense = {5'h00, cond.reg_fault} & FTBI_REG_BITS; // [RQ4] [RQ16]
        next_temp_sense = 8'h00;
        next_temp_sense[FTBI_TEMP_LOW_POS] = cond.temp_above_low; // [RQ9]
        next_temp_sense[FTBI_TEMP_HIGH_POS] = cond.temp_above_high; // [RQ10]
    end

    // Sense registers.
    // The registered copy is also the reference against which crossings are found.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_fault_sense <= FTBI_SENSE_RESET;
            temp_sense <= FTBI_SENSE_RESET;
        end else if (clk_en) begin
            reg_fault_sense <= next_reg_fault_sense;
            temp_sense <= next_temp_sense;
        end
    end

    // Status group: write one to clear, with a set taking priority over a clear.
    // Giving the set priority means an event that lands in the cycle of a clear is never lost;
    // the price is that the host may see a bit it has just cleared come back at once.
    always_comb begin
        logic [7:0] clr;
        // Only a real write may clear; an address with no strobe leaves status alone.
        clr = 8'h00;
        if (req.wr_en) begin
            clr = req.wr_data;
        end
        // A change of the registered level in either direction is a crossing.
        temp_set = (next_temp_sense ^ temp_sense) & FTBI_TEMP_BITS; // [RQ5]
        next_reg_fault_stat = reg_fault_stat;
        next_temp_stat = temp_stat;
        next_btn_stat = btn_stat;
        if (req.addr == FTBI_REG_FAULT_STAT_ADDR) begin
            next_reg_fault_stat = reg_fault_stat & ~clr; // [RQ6]
        end
        if (req.addr == FTBI_TEMP_STAT_ADDR) begin
            next_temp_stat = temp_stat & ~clr; // [RQ6]
        end
        if (req.addr == FTBI_BTN_STAT_ADDR) begin
            next_btn_stat = btn_stat & ~clr; // [RQ6]
        end
        // Regulator events are latched from the live fault level, so a fault that is still
        // present cannot be cleared away.
        next_reg_fault_stat = (next_reg_fault_stat | next_reg_fault_sense)
            & FTBI_REG_BITS; // [RQ7]
        next_temp_stat = (next_temp_stat | temp_set) & FTBI_TEMP_BITS; // [RQ7]
        next_btn_stat = (next_btn_stat | btn_set) & FTBI_BTN_BITS; // [RQ7]
    end

    // Status registers.
    // Unused positions are masked off before they are stored, so they always read zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_fault_stat <= FTBI_STAT_RESET;
            temp_stat <= FTBI_STAT_RESET;
            btn_stat <= FTBI_STAT_RESET;
        end else if (clk_en) begin
            reg_fault_stat <= next_reg_fault_stat;
            temp_stat <= next_temp_stat;
            btn_stat <= next_btn_stat;
        end
    end

    // Mask group: only implemented bits are stored, so unused positions read back as zero.
    // A mask write takes effect on the pin one cycle later, like any status change.
    always_comb begin
        next_reg_fault_mask = reg_fault_mask;
        next_temp_mask = temp_mask;
        next_btn_mask = btn_mask;
        if (req.wr_en && req.addr == FTBI_REG_FAULT_MASK_ADDR) begin
            next_reg_fault_mask = req.wr_data & FTBI_REG_BITS; // [RQ3] [RQ16]
        end
        if (req.wr_en && req.addr == FTBI_TEMP_MASK_ADDR) begin
            next_temp_mask = req.wr_data & FTBI_TEMP_BITS; // [RQ8] [RQ16]
        end
        if (req.wr_en && req.addr == FTBI_BTN_MASK_ADDR) begin
            next_btn_mask = req.wr_data & FTBI_BTN_BITS; // [RQ16]
        end
    end

    // Mask registers; every source starts masked so nothing reaches the pin before setup.
    // The host must clear a mask bit on purpose before its source can raise a request.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_fault_mask <= FTBI_REG_MASK_RESET;
            temp_mask <= FTBI_TEMP_MASK_RESET;
            btn_mask <= FTBI_BTN_MASK_RESET;
        end else if (clk_en) begin
            reg_fault_mask <= next_reg_fault_mask;
            temp_mask <= next_temp_mask;
            btn_mask <= next_btn_mask;
        end
    end

    // Read data is captured on the read strobe and held otherwise, so a host that samples
    // late still sees the byte it asked for; a read never clears anything.
    // Unmapped addresses answer zero rather than holding the previous byte.
    always_comb begin
        next_rd_data = rd_data;
        if (req.rd_en) begin
            case (req.addr)
                FTBI_REG_FAULT_STAT_ADDR: next_rd_data = reg_fault_stat;
                FTBI_REG_FAULT_MASK_ADDR: next_rd_data = reg_fault_mask;
                FTBI_REG_FAULT_SENSE_ADDR: next_rd_data = reg_fault_sense;
                FTBI_TEMP_STAT_ADDR: next_rd_data = temp_stat;
                FTBI_TEMP_MASK_ADDR: next_rd_data = temp_mask;
                FTBI_TEMP_SENSE_ADDR: next_rd_data = temp_sense;
                FTBI_BTN_STAT_ADDR: next_rd_data = btn_stat;
                FTBI_BTN_MASK_ADDR: next_rd_data = btn_mask;
                default: next_rd_data = 8'h00; // [RQ16]
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (clk_en) begin
            rd_data <= next_rd_data;
        end
    end

    // The pin is computed from registered status so it never glitches; the cost is one
    // cycle of latency between a status or mask change and the pin.
    always_comb begin
        next_irq_request_low = ~(|(reg_fault_stat & ~reg_fault_mask) // [RQ1] [RQ2] [RQ15]
            | |(temp_stat & ~temp_mask)
            | |(btn_stat & ~btn_mask));
    end

    // Pin register; the pin idles released so a reset never raises a request.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_request_low <= 1'b1;
        end else if (clk_en) begin
            irq_request_low <= next_irq_request_low;
        end
    end

endmodule

// [ftbi_pkg.sv]
// Package with register map, field layout, reset values and timing counts of the interrupt block.
package ftbi_pkg;

    // Register offsets.
    localparam logic [7:0] FTBI_REG_FAULT_STAT_ADDR = 8'h18;
    localparam logic [7:0] FTBI_REG_FAULT_MASK_ADDR = 8'h19;
    localparam logic [7:0] FTBI_REG_FAULT_SENSE_ADDR = 8'h1a;
    localparam logic [7:0] FTBI_TEMP_STAT_ADDR = 8'h20;
    localparam logic [7:0] FTBI_TEMP_MASK_ADDR = 8'h21;
    localparam logic [7:0] FTBI_TEMP_SENSE_ADDR = 8'h22;
    localparam logic [7:0] FTBI_BTN_STAT_ADDR = 8'h24;
    localparam logic [7:0] FTBI_BTN_MASK_ADDR = 8'h25;

    // Implemented bit positions per register group; all other bits read zero.
    localparam logic [7:0] FTBI_REG_BITS = 8'h07;
    localparam logic [7:0] FTBI_TEMP_BITS = 8'h05;
    localparam logic [7:0] FTBI_BTN_BITS = 8'h0f;

    // Field positions.
    localparam int FTBI_TEMP_LOW_POS = 0;
    localparam int FTBI_TEMP_HIGH_POS = 2;
    localparam int FTBI_BTN_PUSH_POS = 0;
    localparam int FTBI_BTN_HOLD1_POS = 1;
    localparam int FTBI_BTN_HOLD2_POS = 2;
    localparam int FTBI_BTN_HOLD3_POS = 3;

    // Reset values.
    localparam logic [7:0] FTBI_STAT_RESET = 8'h00;
    localparam logic [7:0] FTBI_SENSE_RESET = 8'h00;
    localparam logic [7:0] FTBI_REG_MASK_RESET = 8'h07;
    localparam logic [7:0] FTBI_TEMP_MASK_RESET = 8'h05;
    localparam logic [7:0] FTBI_BTN_MASK_RESET = 8'h0f;

    // Timing: clock rate, times in milliseconds, derived cycle counts.
    localparam int unsigned FTBI_CLK_HZ = 20000000;
    localparam int unsigned FTBI_FALL_DEBOUNCE_MS = 32;
    localparam int unsigned FTBI_RISE_DEBOUNCE_MS = 32;
    localparam int unsigned FTBI_HOLD1_MS = 1000;
    localparam int unsigned FTBI_HOLD2_MS = 2000;
    localparam int unsigned FTBI_HOLD3_MS = 3000;
    localparam int unsigned FTBI_FALL_DEBOUNCE_CYC = FTBI_CLK_HZ / 1000 * FTBI_FALL_DEBOUNCE_MS;
    localparam int unsigned FTBI_RISE_DEBOUNCE_CYC = FTBI_CLK_HZ / 1000 * FTBI_RISE_DEBOUNCE_MS;
    localparam int unsigned FTBI_HOLD1_CYC = FTBI_CLK_HZ / 1000 * FTBI_HOLD1_MS;
    localparam int unsigned FTBI_HOLD2_CYC = FTBI_CLK_HZ / 1000 * FTBI_HOLD2_MS;
    localparam int unsigned FTBI_HOLD3_CYC = FTBI_CLK_HZ / 1000 * FTBI_HOLD3_MS;

    // Register access request as seen from the control interface front end.
    typedef struct packed {
        logic [7:0] addr;
        logic wr_en;
        logic rd_en;
        logic [7:0] wr_data;
    } ftbi_req_t;

    // Live condition inputs from the analog monitors.
    typedef struct packed {
        logic [2:0] reg_fault;
        logic temp_above_low;
        logic temp_above_high;
    } ftbi_cond_t;

    // Button debounce states.
    typedef enum logic [3:0] {
        FTBI_BTN_RELEASED = 4'b0001,
        FTBI_BTN_FALLING = 4'b0010,
        FTBI_BTN_PRESSED = 4'b0100,
        FTBI_BTN_RISING = 4'b1000
    } ftbi_btn_state_t;

endpackage

// [ftbi_irq_checker.sv]
// Concurrent checks on the ports of the interrupt status, mask and sense block.
`timescale 1ns/100ps
module ftbi_irq_checker
    import ftbi_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port.
    input wire ftbi_req_t req,
    input wire logic [7:0] rd_data,
    // Conditions, button and request pin.
    input wire ftbi_cond_t cond,
    input wire logic power_button,
    input wire logic irq_request_low
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [7:0] reg_m;
    logic [7:0] tmp_m;
    logic [7:0] btn_m;

    // Mask copies follow the host's writes, since the masks themselves are not visible.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_m <= FTBI_REG_MASK_RESET;
            tmp_m <= FTBI_TEMP_MASK_RESET;
            btn_m <= FTBI_BTN_MASK_RESET;
        end else if (clk_en && req.wr_en) begin
            if (req.addr == FTBI_REG_FAULT_MASK_ADDR) reg_m <= req.wr_data & FTBI_REG_BITS;
            if (req.addr == FTBI_TEMP_MASK_ADDR) tmp_m <= req.wr_data & FTBI_TEMP_BITS;
            if (req.addr == FTBI_BTN_MASK_ADDR) btn_m <= req.wr_data & FTBI_BTN_BITS;
        end
    end

    AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n && clk_en
        |=> irq_request_low && rd_data == 8'h00) else $error("reset state wrong");
    AST_SENSE_REG: assert property (req.rd_en && req.addr == 8'h1a && $past(rst_n)
        && $stable(cond.reg_fault) |=> rd_data == {5'h00, $past(cond.reg_fault)})
        else $error("regulator sense read wrong");
    AST_SENSE_TEMP: assert property (req.rd_en && req.addr == 8'h22 && $past(rst_n)
        && $stable(cond) |=> rd_data == {5'h00, $past(cond.temp_above_high), 1'b0,
        $past(cond.temp_above_low)}) else $error("thermal sense read wrong");
    AST_UNUSED_ZERO: assert property (req.rd_en |=> rd_data[7:4] == 4'h0)
        else $error("unused read bits not zero");
    AST_IRQ_LOW: assert property ((|(cond.reg_fault & ~reg_m[2:0]))[*4]
        |-> !irq_request_low) else $error("unmasked fault left pin high");
    AST_IRQ_MASKED: assert property ((reg_m == 8'h07 && tmp_m == 8'h05
        && btn_m == 8'h0f)[*3] |-> irq_request_low) else $error("masked event drove pin");
    AST_READ_HOLDS: assert property (!req.rd_en |=> $stable(rd_data))
        else $error("read data changed without read");
    AST_MASK_RW: assert property (req.wr_en && req.addr == 8'h19 ##2 req.rd_en
        && req.addr == 8'h19 |=> rd_data == ($past(req.wr_data, 3) & 8'h07))
        else $error("regulator mask readback wrong");
    AST_W1C: assert property (req.wr_en && req.addr == 8'h20 && req.wr_data[0]
        && $stable(cond) ##1 $stable(cond) ##1 req.rd_en && req.addr == 8'h20
        && $stable(cond) |=> !rd_data[0]) else $error("status bit not cleared");

    // Main scenarios reached.
    COV_IRQ: cover property ($fell(irq_request_low));
    COV_BTN: cover property (!power_button [*8]);
    COV_CLR: cover property (req.wr_en && req.addr == 8'h24);
endmodule

// [ftbi_host_model.sv]
// Host model that issues single byte register accesses on the strobe port.
`timescale 1ns/100ps
module ftbi_host_model
    import ftbi_pkg::*;
(
    // Clock.
    input wire logic clock,
    // Request toward the device.
    output ftbi_req_t req
);
    // Idle port at time zero.
    initial begin
        req = '0;
    end

    // One access per call; the leading wait leaves an idle cycle so strobes never merge.
    task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data);
        @(negedge clock);
        req.addr = addr;
        req.wr_en = wr;
        req.rd_en = !wr;
        req.wr_data = data;
        @(negedge clock);
        req.wr_en = 1'b0;
        req.rd_en = 1'b0;
        req.addr = ~addr; // Released lines show a changed value, not the last one.
        req.wr_data = ~data;
    endtask
endmodule

// [ftbi_irq_tb_top.sv]
// Self-checking testbench for the interrupt status, mask and sense block.
`timescale 1ns/100ps
module ftbi_irq_tb_top;
    import ftbi_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    ftbi_req_t req;
    ftbi_cond_t cond = '0;
    logic power_button = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] rd_data;
    logic irq_request_low;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int checks = 0;
    int seed = 32'h2c9b;
    logic [7:0] f;
    logic [7:0] m;
    localparam logic [7:0] RADR [9] = '{8'h18, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h22, 8'h24,
        8'h25, 8'h30};
    localparam logic [7:0] RVAL [9] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00,
        8'h0f, 8'h00};

    always #25 clock = ~clock;

    // Short debounce and hold counts keep the run brief.
    ftbi_irq #(.FALL_DEBOUNCE_CYCLES(4), .RISE_DEBOUNCE_CYCLES(4), .HOLD1_CYCLES(20),
        .HOLD2_CYCLES(40), .HOLD3_CYCLES(60)) ftbi_irq_inst (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .req(req), .rd_data(rd_data), .cond(cond),
        .power_button(power_button), .irq_request_low(irq_request_low));
    ftbi_host_model ftbi_host_model_inst (.clock(clock), .req(req));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        ftbi_host_model_inst.access(a, 1'b0, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ftbi_host_model_inst.access(a, 1'b1, d);
    endtask
    task automatic check_rd(input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error rd_data expected %h seen %h", e, s);
        end
    endtask
    task automatic check_irq(input logic e);
        checks++;
        if (irq_request_low !== e) begin
            mismatches++;
            $display("Error irq_request_low expected %b seen %b", e, irq_request_low);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Read data lands one edge after the strobe, so the oldest note is taken then.
    always @(posedge clock) rd_seen <= req.rd_en && clk_en;
    always @(negedge clock) begin
        if (rd_seen) check_rd(exp_q.pop_front(), rd_data);
    end

    // Hang guard, far beyond the roughly 340 cycles the sequence needs.
    initial begin
        #(50 * 20000);
        mismatches++;
        give_verdict();
    end

    initial begin
        wait_n(5);
        rst_n = 1'b1;
        foreach (RADR[i]) rd(RADR[i], RVAL[i]);
        wr(8'h1a, 8'hff);
        wr(8'h21, 8'hff);
        rd(8'h1a, 8'h00);
        rd(8'h21, 8'h05);
        // Random faults against random regulator masks; other groups stay masked.
        repeat (8) begin
            f = 8'($random(seed)) & 8'h07;
            m = 8'($random(seed));
            cond.reg_fault = f[2:0];
            wait_n(3);
            wr(8'h18, 8'hff);
            wr(8'h19, m);
            rd(8'h19, m & 8'h07);
            wait_n(3);
            rd(8'h1a, f);
            rd(8'h18, f);
            check_irq(~|(f & ~m));
        end
        cond.reg_fault = 3'h0;
        wait_n(3);
        wr(8'h18, 8'hff);
        wr(8'h19, 8'h07);
        rd(8'h18, 8'h00);
        // Thermal crossings in both directions.
        wr(8'h21, 8'h00);
        cond.temp_above_low = 1'b1;
        wait_n(4);
        rd(8'h22, 8'h01);
        rd(8'h20, 8'h01);
        check_irq(1'b0);
        wr(8'h20, 8'h01);
        rd(8'h20, 8'h00);
        check_irq(1'b1);
        cond.temp_above_low = 1'b0;
        wait_n(4);
        rd(8'h20, 8'h01);
        wr(8'h20, 8'h01);
        cond.temp_above_low = 1'b1;
        cond.temp_above_high = 1'b1;
        wait_n(4);
        rd(8'h22, 8'h05);
        wr(8'h20, 8'h04);
        rd(8'h20, 8'h01);
        wr(8'h21, 8'h05);
        wait_n(3);
        check_irq(1'b1);
        wr(8'h20, 8'h05);
        // Frozen clock enable: a write and a press during the freeze must leave no trace.
        clk_en = 1'b0;
        wr(8'h21, 8'h00);
        power_button = 1'b0;
        wait_n(10);
        power_button = 1'b1;
        clk_en = 1'b1;
        wait_n(2);
        rd(8'h21, 8'h05);
        rd(8'h24, 8'h00);
        check_irq(1'b1);
        // Button: a short bounce, a long hold, then a release.
        wr(8'h25, 8'h00);
        power_button = 1'b0;
        wait_n(2);
        power_button = 1'b1;
        wait_n(6);
        rd(8'h24, 8'h00);
        power_button = 1'b0;
        wait_n(30);
        rd(8'h24, 8'h03);
        check_irq(1'b0);
        wr(8'h24, 8'h0f);
        wait_n(40);
        rd(8'h24, 8'h0c);
        wr(8'h24, 8'h0f);
        power_button = 1'b1;
        wait_n(8);
        rd(8'h24, 8'h01);
        wr(8'h24, 8'h0f);
        wait_n(10);
        rd(8'h24, 8'h00);
        check_irq(1'b1);
        wait_n(4);
        give_verdict();
    end
endmodule

bind ftbi_irq ftbi_irq_checker ftbi_irq_checker_inst (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .req(req), .rd_data(rd_data), .cond(cond),
    .power_button(power_button), .irq_request_low(irq_request_low));
